/* rtl/apc_map.svh */
`ifndef APC_MAP_SVH
`define APC_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define APC_OFS_CTRL 8'h00
`define APC_OFS_DBYP 8'h04
`define APC_OFS_GAIN 8'h08
`define APC_OFS_FIXRUN 8'h0c
`define APC_OFS_FIXSU 8'h10
`define APC_OFS_SSLOPE 8'h14
`define APC_OFS_SICPT 8'h18
`define APC_OFS_RSLOPE 8'h1c
`define APC_OFS_RICPT 8'h20
`define APC_OFS_SURB 8'h24
`define APC_OFS_HIFLOW 8'h28
`define APC_OFS_DLVL 8'h2c
`define APC_OFS_STAT 8'h30
`define APC_OFS_POWER 8'h34
`define APC_OFS_STP 8'h38
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define APC_CTRL_SU 0
`define APC_CTRL_BEN 1
`define APC_CTRL_BLO 2
`define APC_CTRL_BHI 3
`define APC_GAIN_RST 16'h1000
`define APC_GAIN_FRAC 12
`define APC_SLOPE_FRAC 8
`define APC_SP_RST 16'h04b0
`define APC_SU_RST 16'h00c8
`define APC_HIFLOW_RST 16'hffff
`define APC_DLVL_RST 16'h03e8
// ----------------------------------------
// Limits: active detector count, then hysteresis and power in units of 0.1 percent
// ----------------------------------------
`define APC_MIN_ACTIVE 17
`define APC_HYST 10
`define APC_PWR_MAX 1250
// ----------------------------------------
// Timing
// ----------------------------------------
`define APC_CLK_MHZ 125
`define APC_TAU_MS 6000
`define APC_TS_US 1000
`define APC_SAMPLE_CYC (`APC_TS_US * `APC_CLK_MHZ)
`define APC_ALPHA_FRAC 16
`define APC_ALPHA ((`APC_TS_US * 65536) / (`APC_TAU_MS * 1000))
`endif

/* rtl/apc_pkg.sv */
package apc_pkg;
  typedef enum logic [1:0] {S_IDLE, S_ACC, S_DIV, S_EVAL} apc_state_t;
  typedef struct packed {
    logic [15:0] loopA;
    logic [15:0] loopB;
    logic [2:0] peerTrip;
  } apc_field_t;
  typedef struct packed {
    logic scram;
    logic rodBlock;
    logic inop;
    logic hiFlow;
  } apc_trips_t;
endpackage

/* rtl/apc_channel.sv */
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Average up to 31 detector readings
// - Bypassed detectors leave sum and divisor
// - Scale average by stored gain
// - Total flow is sum of loops
// - Flow-biased setpoints follow configured slope
// - Thermal power via 6 s filter
// - Trip when value exceeds stored setpoint
// - Voter trips on two unbypassed channels
// - Voter trip asserts for every voter
// - Single tripped channel gives half-trip only
// - Operator bypasses at most one channel
// - Protection trips active low, fail tripped
// - Detector trips fail to tripped state
// - Detector trips 0.1 step, 1 percent hysteresis
// - Startup uses lower fixed scram setpoint
// - Own rod block qualified by mode
// - Rod block direct, scram via voter
// - Power indication 0 to 125 percent
// - Fewer than 17 active gives inoperative
// - High flow gives rod block and alarm
`include "apc_map.svh"
module apc_channel #(
  parameter int NDET = 31,
  parameter int DW = 16,
  parameter int SAMPLE_CYC = `APC_SAMPLE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NDET*DW-1:0] detIn,
  input wire apc_pkg::apc_field_t fieldIn,
  output logic protTripN,
  output logic halfTrip,
  output logic chTripN,
  output logic rodBlockN,
  output logic flowAlarm,
  output logic [NDET-1:0] detTripN,
  output logic [15:0] powerInd,
  output logic [15:0] stpInd
);
  import apc_pkg::*;

  if (NDET < `APC_MIN_ACTIVE || NDET > 31 || DW != 16 || SAMPLE_CYC < 64) begin : g_chk
    $error("apc_channel: unsupported parameter values");
  end

  localparam int SW = DW + 5;
  localparam logic [39:0] ALPHA = 40'(`APC_ALPHA);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [23:0] flowSp(input logic [15:0] slope, input logic [15:0] icpt,
                                         input logic [16:0] flow);
    logic [32:0] prod;
    prod = 33'(slope) * 33'(flow);
    return 24'(icpt) + 24'(prod >> `APC_SLOPE_FRAC);
  endfunction

  function automatic logic [1:0] countTrips(input logic [3:0] trips, input logic ben,
                                            input logic [1:0] bidx);
    logic [1:0] n;
    n = 2'd0;
    for (int i = 0; i < 4; i++) begin
      if (trips[i] && !(ben && bidx == 2'(i)) && n != 2'd2) begin
        n = n + 2'd1;
      end
    end
    return n;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [NDET*DW-1:0] detS1_q, detS2_q;
  apc_field_t fldS1_q, fldS2_q;
  always_ff @(posedge clk) begin
    detS1_q <= detIn;
    detS2_q <= detS1_q;
    fldS1_q <= fieldIn;
    fldS2_q <= fldS1_q;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0] ctrl_q;
  logic [NDET-1:0] dbyp_q;
  logic [15:0] gain_q, fixRun_q, fixSu_q, sSlope_q, sIcpt_q, rSlope_q, rIcpt_q;
  logic [15:0] suRb_q, hiFlow_q, dLvl_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  apc_trips_t trips_q;
  logic [4:0] active_q;
  logic [15:0] power_q;
  logic [31:0] stpAcc_q;

  wire apbSetup = psel && !penable;
  wire apbWr = psel && penable && pready_q && pwrite;
  wire [3:0] ctrlW = pwdata[3:0];
  wire [NDET-1:0] dbypW = pwdata[NDET-1:0];
  wire [15:0] wd16 = pwdata[15:0];
  wire [16:0] flowTot = 17'(fldS2_q.loopA) + 17'(fldS2_q.loopB);

  logic [31:0] rdMux;
  logic rdHit;
  always_comb begin
    rdHit = 1'b1;
    if (paddr == `APC_OFS_CTRL) rdMux = 32'(ctrl_q);
    else if (paddr == `APC_OFS_DBYP) rdMux = 32'(dbyp_q);
    else if (paddr == `APC_OFS_GAIN) rdMux = 32'(gain_q);
    else if (paddr == `APC_OFS_FIXRUN) rdMux = 32'(fixRun_q);
    else if (paddr == `APC_OFS_FIXSU) rdMux = 32'(fixSu_q);
    else if (paddr == `APC_OFS_SSLOPE) rdMux = 32'(sSlope_q);
    else if (paddr == `APC_OFS_SICPT) rdMux = 32'(sIcpt_q);
    else if (paddr == `APC_OFS_RSLOPE) rdMux = 32'(rSlope_q);
    else if (paddr == `APC_OFS_RICPT) rdMux = 32'(rIcpt_q);
    else if (paddr == `APC_OFS_SURB) rdMux = 32'(suRb_q);
    else if (paddr == `APC_OFS_HIFLOW) rdMux = 32'(hiFlow_q);
    else if (paddr == `APC_OFS_DLVL) rdMux = 32'(dLvl_q);
    else if (paddr == `APC_OFS_STAT) rdMux = {3'h0, flowTot, 3'h0, active_q, trips_q};
    else if (paddr == `APC_OFS_POWER) rdMux = 32'(power_q);
    else if (paddr == `APC_OFS_STP) rdMux = 32'(stpAcc_q[31:16]);
    else begin
      rdMux = 32'h0;
      rdHit = 1'b0;
    end
  end

  // Zero wait: pready rises in the access phase of every transfer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= apbSetup;
      pslverr_q <= apbSetup && !rdHit;
      prdata_q <= (apbSetup && !pwrite) ? rdMux : 32'h0;
    end
  end

  // A 2-bit index can name only one channel, so double bypass cannot be set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= 4'h0;
      dbyp_q <= '0;
      gain_q <= `APC_GAIN_RST;
      fixRun_q <= `APC_SP_RST;
      fixSu_q <= `APC_SU_RST;
      sSlope_q <= 16'h0;
      sIcpt_q <= `APC_SP_RST;
      rSlope_q <= 16'h0;
      rIcpt_q <= `APC_SP_RST;
      suRb_q <= `APC_SU_RST;
      hiFlow_q <= `APC_HIFLOW_RST;
      dLvl_q <= `APC_DLVL_RST;
    end else if (apbWr) begin
      if (paddr == `APC_OFS_CTRL) ctrl_q <= ctrlW;
      else if (paddr == `APC_OFS_DBYP) dbyp_q <= dbypW;
      else if (paddr == `APC_OFS_GAIN) gain_q <= wd16;
      else if (paddr == `APC_OFS_FIXRUN) fixRun_q <= wd16;
      else if (paddr == `APC_OFS_FIXSU) fixSu_q <= wd16;
      else if (paddr == `APC_OFS_SSLOPE) sSlope_q <= wd16;
      else if (paddr == `APC_OFS_SICPT) sIcpt_q <= wd16;
      else if (paddr == `APC_OFS_RSLOPE) rSlope_q <= wd16;
      else if (paddr == `APC_OFS_RICPT) rIcpt_q <= wd16;
      else if (paddr == `APC_OFS_SURB) suRb_q <= wd16;
      else if (paddr == `APC_OFS_HIFLOW) hiFlow_q <= wd16;
      else if (paddr == `APC_OFS_DLVL) dLvl_q <= wd16;
    end
  end

  // ----------------------------------------
  // Sample timer and averaging engine
  // ----------------------------------------
  logic [31:0] tick_q;
  apc_state_t state_q;
  logic [4:0] idx_q, cnt_q, bit_q;
  logic [SW-1:0] sum_q;
  logic [5:0] rem_q;

  wire tickNow = (tick_q == 32'(SAMPLE_CYC - 1));
  wire [DW-1:0] detCur = detS2_q[idx_q*DW +: DW];
  wire detUse = !dbyp_q[idx_q];
  wire [5:0] remSh = {rem_q[4:0], sum_q[SW-1]};
  wire remGe = remSh >= 6'(cnt_q);
  wire [36:0] scaled = 37'(sum_q) * 37'(gain_q);
  wire [36:0] pwrRaw = scaled >> `APC_GAIN_FRAC;
  wire [15:0] pwrNew = (cnt_q == 5'd0) ? 16'h0 :
    (pwrRaw > 37'(`APC_PWR_MAX)) ? 16'(`APC_PWR_MAX) : pwrRaw[15:0];
  wire signed [39:0] diff = $signed({8'h0, pwrNew, 16'h0}) - $signed({8'h0, stpAcc_q});
  wire signed [39:0] step = (diff * $signed(ALPHA)) >>> `APC_ALPHA_FRAC;
  wire [31:0] stpNew = 32'($signed({8'h0, stpAcc_q}) + step);

  always_ff @(posedge clk) begin
    if (sys_rst || tickNow) tick_q <= 32'h0;
    else tick_q <= tick_q + 32'h1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      idx_q <= 5'd0;
      cnt_q <= 5'd0;
      bit_q <= 5'd0;
      sum_q <= '0;
      rem_q <= 6'h0;
    end else begin
      case (state_q)
        S_IDLE: if (tickNow) begin
          state_q <= S_ACC;
          idx_q <= 5'd0;
          cnt_q <= 5'd0;
          sum_q <= '0;
        end
        S_ACC: begin
          if (detUse) begin
            sum_q <= sum_q + SW'(detCur);
            cnt_q <= cnt_q + 5'd1;
          end
          idx_q <= idx_q + 5'd1;
          if (idx_q == 5'(NDET - 1)) begin
            state_q <= S_DIV;
            bit_q <= 5'd0;
            rem_q <= 6'h0;
          end
        end
        S_DIV: begin
          rem_q <= remGe ? remSh - 6'(cnt_q) : remSh;
          sum_q <= {sum_q[SW-2:0], remGe};
          bit_q <= bit_q + 5'd1;
          if (bit_q == 5'(SW - 1)) state_q <= S_EVAL;
        end
        S_EVAL: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Trip evaluation
  // ----------------------------------------
  wire startup = ctrl_q[`APC_CTRL_SU];
  wire [23:0] spScram = flowSp(sSlope_q, sIcpt_q, flowTot);
  wire [23:0] spRb = flowSp(rSlope_q, rIcpt_q, flowTot);
  wire [15:0] fixSp = startup ? fixSu_q : fixRun_q;
  wire inopNew = cnt_q < 5'(`APC_MIN_ACTIVE);
  wire hiFlowNew = flowTot > 17'(hiFlow_q);
  wire scramNew = (pwrNew > fixSp) || (24'(stpNew[31:16]) > spScram);
  wire rbNew = startup ? (pwrNew > suRb_q) : (24'(stpNew[31:16]) > spRb);
  wire evalNow = state_q == S_EVAL;

  logic [NDET-1:0] dTrip_q;
  logic [NDET-1:0] dTripD;
  // Inverted copy in its own flop so the pins come straight off a register
  logic [NDET-1:0] detTripN_q;
  always_comb begin
    dTripD = dTrip_q;
    for (int i = 0; i < NDET; i++) begin
      if (detS2_q[i*DW +: DW] > dLvl_q) dTripD[i] = 1'b1;
      else if (17'(detS2_q[i*DW +: DW]) + 17'(`APC_HYST) < 17'(dLvl_q)) dTripD[i] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trips_q <= '{scram: 1'b1, rodBlock: 1'b1, inop: 1'b1, hiFlow: 1'b0};
      active_q <= 5'd0;
      power_q <= 16'h0;
      stpAcc_q <= 32'h0;
      dTrip_q <= '1;
      detTripN_q <= '0;
    end else if (evalNow) begin
      trips_q.scram <= scramNew;
      trips_q.inop <= inopNew;
      trips_q.hiFlow <= hiFlowNew;
      trips_q.rodBlock <= rbNew || hiFlowNew || inopNew;
      active_q <= cnt_q;
      power_q <= pwrNew;
      stpAcc_q <= stpNew;
      dTrip_q <= dTripD;
      detTripN_q <= ~dTripD;
    end
  end

  // ----------------------------------------
  // Two-out-of-four voter, own channel is index 0
  // ----------------------------------------
  wire ownTrip = trips_q.scram || trips_q.inop;
  wire [3:0] allTrip = {fldS2_q.peerTrip, ownTrip};
  wire [1:0] nTrip = countTrips(allTrip, ctrl_q[`APC_CTRL_BEN],
    ctrl_q[`APC_CTRL_BHI:`APC_CTRL_BLO]);

  // Outputs fail low so that a dead board reads as tripped
  logic protTripN_q, halfTrip_q, chTripN_q, rodBlockN_q, flowAlarm_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      protTripN_q <= 1'b0;
      halfTrip_q <= 1'b0;
      chTripN_q <= 1'b0;
      rodBlockN_q <= 1'b0;
      flowAlarm_q <= 1'b0;
    end else begin
      protTripN_q <= !(nTrip == 2'd2);
      halfTrip_q <= nTrip == 2'd1;
      chTripN_q <= !ownTrip;
      rodBlockN_q <= !trips_q.rodBlock;
      flowAlarm_q <= trips_q.hiFlow;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign protTripN = protTripN_q;
  assign halfTrip = halfTrip_q;
  assign chTripN = chTripN_q;
  assign rodBlockN = rodBlockN_q;
  assign flowAlarm = flowAlarm_q;
  assign detTripN = detTripN_q;
  assign powerInd = power_q;
  assign stpInd = stpAcc_q[31:16];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // All checks idle while reset is held
  a_vote_two: assert property (@(posedge clk) disable iff (sys_rst)
    nTrip == 2'd2 |=> !protTripN) else $error("two trips without voter trip");
  a_vote_none: assert property (@(posedge clk) disable iff (sys_rst)
    nTrip != 2'd2 |=> protTripN) else $error("voter trip without two trips");
  a_half_trip: assert property (@(posedge clk) disable iff (sys_rst)
    halfTrip |-> protTripN) else $error("half trip drove protection trip");
  a_inop_count: assert property (@(posedge clk) disable iff (sys_rst)
    evalNow && cnt_q < 5'd17 |=> trips_q.inop ##1 !chTripN) else $error("inop missed");
  a_power_clip: assert property (@(posedge clk) disable iff (sys_rst)
    powerInd <= 16'd1250) else $error("power indication over range");
  a_sample_rate: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == S_IDLE && !tickNow |=> state_q == S_IDLE) else $error("engine ran early");
  a_acc_len: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(state_q == S_ACC) |-> ##30 (state_q == S_ACC && idx_q == 5'd30) ##1 state_q == S_DIV)
    else $error("accumulate length wrong");
  a_byp_skip: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == S_ACC && !detUse |=> cnt_q == $past(cnt_q)) else $error("bypassed counted");
  a_flow_alarm: assert property (@(posedge clk) disable iff (sys_rst)
    evalNow && hiFlowNew |-> ##2 flowAlarm && !rodBlockN) else $error("high flow missed");
  a_fix_scram: assert property (@(posedge clk) disable iff (sys_rst)
    evalNow && pwrNew > fixSp |-> ##2 !chTripN) else $error("fixed scram missed");
  a_stp_filter: assert property (@(posedge clk) disable iff (sys_rst)
    evalNow && {pwrNew, 16'h0} >= stpAcc_q |=>
    stpAcc_q >= $past(stpAcc_q) && stpAcc_q <= {$past(pwrNew), 16'h0})
    else $error("filter overshoot");
  a_rb_mode: assert property (@(posedge clk) disable iff (sys_rst)
    evalNow && startup && pwrNew > suRb_q |-> ##2 !rodBlockN)
    else $error("startup rod block missed");
  a_flow_sp: assert property (@(posedge clk) disable iff (sys_rst)
    evalNow && 24'(stpNew[31:16]) > spScram |-> ##2 !chTripN)
    else $error("flow-biased scram missed");
  a_det_trip: assert property (@(posedge clk) disable iff (sys_rst)
    evalNow && detS2_q[5*DW +: DW] > dLvl_q |=> !detTripN[5])
    else $error("detector trip missed");
endmodule
`default_nettype wire

/* sim/apc_peer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Peer channels and loop flow transmitters
// ----------------------------------------
module apc_peer_model (
  input wire logic clk,
  input wire logic [2:0] tripCmd,
  input wire logic [15:0] flowA,
  input wire logic [15:0] flowB,
  output var apc_pkg::apc_field_t fieldOut
);
  import apc_pkg::*;
  // Peers have their own supplies, so our reset never clears them
  always @(posedge clk) begin
    fieldOut.peerTrip <= tripCmd;
    fieldOut.loopA <= flowA;
    fieldOut.loopB <= flowB;
  end
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "apc_map.svh"
module testbench;
  import apc_pkg::*;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  localparam int SP = 200;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, protTripN, halfTrip, chTripN, rodBlockN, flowAlarm;
  logic [31*16-1:0] detIn = {31{16'h01f4}};
  logic [2:0] tripCmd = 3'h0;
  logic [15:0] flowA = 16'h0000;
  logic [15:0] flowB = 16'h0000;
  apc_field_t fieldIn;
  logic [30:0] detTripN;
  logic [15:0] powerInd, stpInd;
  logic [31:0] rdata;
  logic err;
  int failures = 0;
  int cmpCount = 0;
  int n;

  always #4 clk = ~clk;

  apc_peer_model peer (.clk(clk), .tripCmd(tripCmd), .flowA(flowA), .flowB(flowB),
    .fieldOut(fieldIn));

  apc_channel #(.SAMPLE_CYC(SP)) dut (.clk(clk), .sys_rst(sysRst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .detIn(detIn), .fieldIn(fieldIn),
    .protTripN(protTripN), .halfTrip(halfTrip), .chTripN(chTripN), .rodBlockN(rodBlockN),
    .flowAlarm(flowAlarm), .detTripN(detTripN), .powerInd(powerInd), .stpInd(stpInd));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && cmpCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Request is held until pready is seen at an edge, then dropped
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk("pready", pready, 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic xerr);
    apb(1'b0, a, 32'h0);
    chk("prdata", rdata, exp);
    chk("pslverr", err, xerr);
  endtask

  // Two sample periods cover one full evaluation after any input change
  task automatic settle();
    repeat (2 * SP + 120) @(posedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    repeat (16) @(posedge clk);
    chk("protTripN", protTripN, 1'b0);
    chk("chTripN", chTripN, 1'b0);
    chk("detTripN", detTripN, 31'h0);
    sysRst <= 1'b0;
  endtask

  task automatic test_regs();
    rd(`APC_OFS_GAIN, 32'h1000, 1'b0);
    rd(`APC_OFS_FIXRUN, 32'h4b0, 1'b0);
    rd(`APC_OFS_FIXSU, 32'hc8, 1'b0);
    rd(`APC_OFS_DLVL, 32'h3e8, 1'b0);
    rd(8'h3c, 32'h0, 1'b1);
  endtask

  task automatic test_avg();
    settle();
    chk("powerInd", powerInd, 16'h01f4);
    detIn[3*16 +: 16] <= 16'h03e8;
    wr(`APC_OFS_DBYP, 32'h8);
    settle();
    chk("powerInd", powerInd, 16'h01f4);
    apb(1'b0, `APC_OFS_STAT, 32'h0);
    chk("active", rdata[8:4], 5'h1e);
    wr(`APC_OFS_DBYP, 32'h0);
    settle();
    chk("powerInd", powerInd, 16'h0204);
    detIn[3*16 +: 16] <= 16'h01f4;
    wr(`APC_OFS_GAIN, 32'h2000);
    settle();
    chk("powerInd", powerInd, 16'h03e8);
    wr(`APC_OFS_GAIN, 32'h4000);
    settle();
    chk("powerInd", powerInd, 16'h04e2);
    wr(`APC_OFS_GAIN, 32'h1000);
  endtask

  task automatic test_inop();
    wr(`APC_OFS_DBYP, 32'h7fff);
    settle();
    chk("chTripN", chTripN, 1'b0);
    apb(1'b0, `APC_OFS_STAT, 32'h0);
    chk("inop", rdata[1], 1'b1);
    wr(`APC_OFS_DBYP, 32'h3fff);
    settle();
    chk("chTripN", chTripN, 1'b1);
    wr(`APC_OFS_DBYP, 32'h0);
  endtask

  task automatic test_fixed();
    wr(`APC_OFS_FIXRUN, 32'h1f3);
    settle();
    chk("chTripN", chTripN, 1'b0);
    wr(`APC_OFS_FIXRUN, 32'h1f4);
    settle();
    chk("chTripN", chTripN, 1'b1);
    wr(`APC_OFS_FIXRUN, 32'h4b0);
    wr(`APC_OFS_CTRL, 32'h1);
    settle();
    chk("chTripN", chTripN, 1'b0);
    chk("rodBlockN", rodBlockN, 1'b0);
    wr(`APC_OFS_CTRL, 32'h0);
    settle();
    chk("rodBlockN", rodBlockN, 1'b1);
  endtask

  task automatic test_flow();
    flowA <= 16'h0064;
    flowB <= 16'h00c8;
    wr(`APC_OFS_HIFLOW, 32'h12c);
    settle();
    chk("flowAlarm", flowAlarm, 1'b0);
    apb(1'b0, `APC_OFS_STAT, 32'h0);
    chk("flowTot", rdata[28:12], 17'h0012c);
    wr(`APC_OFS_HIFLOW, 32'h12b);
    settle();
    chk("flowAlarm", flowAlarm, 1'b1);
    chk("rodBlockN", rodBlockN, 1'b0);
    wr(`APC_OFS_HIFLOW, 32'hffff);
  endtask

  task automatic test_voter();
    for (int o = 0; o < 2; o++) begin
      wr(`APC_OFS_FIXRUN, (o == 1) ? 32'h190 : 32'h4b0);
      for (int p = 0; p < 8; p++) begin
        tripCmd <= p[2:0];
        settle();
        n = o + $countones(p[2:0]);
        chk("halfTrip", halfTrip, n == 1);
        chk("protTripN", protTripN, n < 2);
      end
    end
    wr(`APC_OFS_FIXRUN, 32'h4b0);
    wr(`APC_OFS_CTRL, 32'h6);
    tripCmd <= 3'b011;
    settle();
    chk("halfTrip", halfTrip, 1'b1);
    chk("protTripN", protTripN, 1'b1);
    wr(`APC_OFS_CTRL, 32'h0);
    tripCmd <= 3'b000;
  endtask

  task automatic test_det();
    detIn[5*16 +: 16] <= 16'h03ed;
    settle();
    chk("detTripN", detTripN, 31'h7fffffdf);
    detIn[5*16 +: 16] <= 16'h03de;
    settle();
    chk("detTripN", detTripN[5], 1'b0);
    detIn[5*16 +: 16] <= 16'h03dd;
    settle();
    chk("detTripN", detTripN[5], 1'b1);
  endtask

  // Mid-run reset, then the filter is modelled from zero and checked once after 40 samples
  task automatic test_stp();
    longint acc;
    int k;
    int s;
    acc = 0;
    k = 0;
    detIn[5*16 +: 16] <= 16'h01f4;
    flowB <= 16'h0000;
    repeat (4) @(posedge clk);
    sysRst <= 1'b1;
    repeat (16) @(posedge clk);
    chk("powerInd", powerInd, 16'h0000);
    chk("rodBlockN", rodBlockN, 1'b0);
    chk("halfTrip", halfTrip, 1'b0);
    chk("flowAlarm", flowAlarm, 1'b0);
    sysRst <= 1'b0;
    while (powerInd === 16'h0000 && k < 2 * SP) begin
      @(posedge clk);
      k++;
    end
    chk("powerInd", powerInd, 16'h01f4);
    for (int i = 0; i < 40; i++) begin
      acc = acc + ((64'h1f40000 - acc) * `APC_ALPHA) / 64'h10000;
    end
    s = int'(acc >>> 16);
    repeat (39 * SP + SP / 2) @(posedge clk);
    chk("stpInd", stpInd, 32'(s));
    rd(`APC_OFS_STP, 32'(s), 1'b0);
    wr(`APC_OFS_SICPT, 32'h0);
    wr(`APC_OFS_SSLOPE, 32'h100);
    flowA <= 16'(s - 1);
    settle();
    chk("chTripN", chTripN, 1'b0);
    flowA <= 16'(s + 1);
    settle();
    chk("chTripN", chTripN, 1'b1);
  endtask

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    test_reset();
    test_regs();
    test_avg();
    test_inop();
    test_fixed();
    test_flow();
    test_voter();
    test_det();
    test_stp();
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
